// ### design/rid_rotate_datapath.sv
`timescale 1ns/10ps
`default_nettype none
// Operation
// - right rotate through carry: old carry into bit 7, bit 0 out to carry
// - destination bit zero: result goes to working register, source untouched
// - bank bit zero: address within access bank, bank select ignored
// - bank bit one: address is bank select register joined with file address
// - destination bit one: result written back into source register
// - bank bit zero with extended set: addresses up to 5Fh are indexed offsets
module rid_rotate_datapath
   import rid_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic sys_rst_in,
   input wire logic clk_en_in,
   input wire logic instr_valid_in,
   input wire logic [15:0] instr_in,
   input wire logic [3:0] bank_select_reg_in,
   input wire logic ext_instr_set_in,
   input wire logic [7:0] index_base_in,
   input wire logic [7:0] mem_rdata_in,
   input wire logic carry_in,
   output logic [11:0] mem_addr_out,
   output logic [7:0] mem_wdata_out,
   output logic mem_we_out,
   output logic [7:0] w_out,
   output logic carry_out,
   output logic negative_out,
   output logic zero_out,
   output logic busy_out
);
   // ----------------------------------------
   // decode
   // ----------------------------------------
   wire logic [5:0] opc = instr_in[RID_OPC_HI:RID_OPC_LO];
   wire logic is_rlnc = (opc == RID_OP_RLNC);
   wire logic is_rrc = (opc == RID_OP_RRC);
   wire logic dest_f = instr_in[RID_DEST_BIT];
   wire logic bank_a = instr_in[RID_BANK_BIT];
   wire logic [7:0] faddr = instr_in[7:0];
   wire logic indexed = !bank_a && ext_instr_set_in && (faddr <= RID_INDEX_LIMIT);
   wire logic [7:0] idx_addr = 8'(index_base_in + faddr);
   // access bank: low part in bank 0, upper part in the top bank
   wire logic [3:0] acc_bank = (faddr < RID_ACCESS_SPLIT) ? RID_ACCESS_LO_BANK : RID_ACCESS_HI_BANK;
   wire logic [11:0] eff_addr = indexed ? {RID_ACCESS_LO_BANK, idx_addr}
      : bank_a ? {bank_select_reg_in, faddr}
      : {acc_bank, faddr};
   wire logic start = instr_valid_in && (is_rlnc || is_rrc);
   // ----------------------------------------
   // state
   // ----------------------------------------
   rid_phase_type ph_reg, ph_next;
   logic busy_reg, busy_next;
   logic op_rrc_reg, dest_f_reg;
   logic [7:0] opnd_reg, res_reg;
   logic [11:0] addr_reg;
   logic [7:0] w_reg;
   logic c_reg, n_reg, z_reg, we_reg;
   // one strobe per phase; each already carries the clock enable, so a low
   // enable freezes every register that one of them enables without a second test
   wire logic take_en = clk_en_in && (ph_reg == RID_Q1) && start;
   wire logic fetch_en = clk_en_in && (ph_reg == RID_Q2);
   wire logic calc_en = clk_en_in && (ph_reg == RID_Q3);
   wire logic store_en = clk_en_in && (ph_reg == RID_Q4);
   // ----------------------------------------
   // phase sequencer
   // ----------------------------------------
   always_comb begin
      case (ph_reg)
         RID_Q1: ph_next = start ? RID_Q2 : RID_Q1;
         RID_Q2: ph_next = RID_Q3;
         RID_Q3: ph_next = RID_Q4;
         RID_Q4: ph_next = RID_Q1;
         default: ph_next = RID_Q1;
      endcase
   end
   // busy is registered so that it leaves the block from a flip-flop; it
   // follows the phase register edge for edge and covers Q2..Q4
   assign busy_next = (ph_next != RID_Q1);
   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         ph_reg <= RID_Q1;
         busy_reg <= RID_FLAG_RST;
      end else if (clk_en_in) begin
         ph_reg <= ph_next;
         busy_reg <= busy_next;
      end
   end
   // ----------------------------------------
   // Q1: decode, latch the operand address
   // ----------------------------------------
   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         op_rrc_reg <= RID_FLAG_RST;
         dest_f_reg <= RID_FLAG_RST;
         addr_reg <= RID_ADDR_RST;
      end else if (take_en) begin
         op_rrc_reg <= is_rrc;
         dest_f_reg <= dest_f;
         addr_reg <= eff_addr;
      end
   end
   // ----------------------------------------
   // Q2: read register f
   // ----------------------------------------
   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         opnd_reg <= RID_W_RST;
      end else if (fetch_en) begin
         opnd_reg <= mem_rdata_in;
      end
   end
   // ----------------------------------------
   // Q3: process data, flags
   // ----------------------------------------
   wire logic [7:0] rot_l = {opnd_reg[6:0], opnd_reg[7]};
   wire logic [7:0] rot_r = {c_reg, opnd_reg[7:1]};
   wire logic [7:0] rot = op_rrc_reg ? rot_r : rot_l;
   // the left rotate keeps the carry it was given at decode; only the right
   // rotate replaces it with the bit shifted out of bit 0
   wire logic c_next = take_en ? carry_in : (calc_en && op_rrc_reg) ? opnd_reg[0] : c_reg;
   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         res_reg <= RID_W_RST;
         n_reg <= RID_FLAG_RST;
         z_reg <= RID_FLAG_RST;
      end else if (calc_en) begin
         res_reg <= rot;
         n_reg <= rot[7];
         z_reg <= (rot == 8'h00);
      end
   end
   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         c_reg <= RID_FLAG_RST;
      end else if (clk_en_in) begin
         c_reg <= c_next;
      end
   end
   // ----------------------------------------
   // Q4: write to destination
   // ----------------------------------------
   // the memory strobe stands for one enabled cycle, in the Q1 that follows
   wire logic we_next = store_en && dest_f_reg;
   wire logic w_load = store_en && !dest_f_reg;
   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         we_reg <= RID_FLAG_RST;
      end else if (clk_en_in) begin
         we_reg <= we_next;
      end
   end
   always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         w_reg <= RID_W_RST;
      end else if (w_load) begin
         w_reg <= res_reg;
      end
   end
   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign mem_addr_out = addr_reg;
   assign mem_wdata_out = res_reg;
   assign mem_we_out = we_reg;
   assign w_out = w_reg;
   assign carry_out = c_reg;
   assign negative_out = n_reg;
   assign zero_out = z_reg;
   assign busy_out = busy_reg;
   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (sys_rst_in);
   sequence s_start;
      clk_en_in && ph_reg == RID_Q1 && start;
   endsequence
   property p_rrc_result;
      s_start ##0 (is_rrc && clk_en_in) ##1 clk_en_in[*2] |=>
         res_reg == {$past(c_reg), $past(opnd_reg[7:1])} && c_reg == $past(opnd_reg[0]);
   endproperty
   a_rrc_result: assert property (p_rrc_result) else $error("rrc result wrong");
   property p_w_dest;
      clk_en_in && ph_reg == RID_Q4 && !dest_f_reg |=> w_reg == $past(res_reg) && !mem_we_out;
   endproperty
   a_w_dest: assert property (p_w_dest) else $error("w destination wrong");
   property p_access;
      s_start ##0 (!bank_a && !indexed) |=>
         addr_reg == {(($past(faddr) < RID_ACCESS_SPLIT) ? RID_ACCESS_LO_BANK : RID_ACCESS_HI_BANK), $past(faddr)};
   endproperty
   a_access: assert property (p_access) else $error("access bank address wrong");
   property p_banked;
      s_start ##0 bank_a |=> addr_reg == {$past(bank_select_reg_in), $past(faddr)};
   endproperty
   a_banked: assert property (p_banked) else $error("banked address wrong");
   property p_f_dest;
      clk_en_in && ph_reg == RID_Q4 && dest_f_reg |=> mem_we_out && $stable(w_reg);
   endproperty
   a_f_dest: assert property (p_f_dest) else $error("file destination wrong");
   property p_indexed;
      s_start ##0 indexed |=> addr_reg == {RID_ACCESS_LO_BANK, 8'($past(index_base_in) + $past(faddr))};
   endproperty
   a_indexed: assert property (p_indexed) else $error("indexed address wrong");
   property p_rlnc;
      clk_en_in && ph_reg == RID_Q3 && !op_rrc_reg |=>
         res_reg == {$past(opnd_reg[6:0]), $past(opnd_reg[7])} && $stable(c_reg) &&
         n_reg == res_reg[7] && z_reg == (res_reg == 8'h00);
   endproperty
   a_rlnc: assert property (p_rlnc) else $error("rlnc result wrong");
   sequence s_full_cycle;
      s_start ##1 clk_en_in[*3];
   endsequence
   property p_one_cycle;
      s_full_cycle |=> ph_reg == RID_Q1 && !busy_out;
   endproperty
   a_one_cycle: assert property (p_one_cycle) else $error("instruction not one cycle");
   property p_busy;
      s_start |=> busy_out;
   endproperty
   a_busy: assert property (p_busy) else $error("busy not raised at decode");
   property p_f_data;
      store_en && dest_f_reg |=> mem_wdata_out == $past(res_reg) && mem_addr_out == $past(addr_reg);
   endproperty
   a_f_data: assert property (p_f_data) else $error("write back data or address wrong");
   property p_freeze;
      !clk_en_in |=> $stable(ph_reg) && $stable(addr_reg) && $stable(res_reg) && $stable(w_reg) && $stable(c_reg);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");
endmodule
`default_nettype wire

// ### design/rid_pkg.sv
package rid_pkg;
   // ----------------------------------------
   // opcode layout of the byte-oriented rotates
   // ----------------------------------------
   localparam logic [5:0] RID_OP_RLNC = 6'h11;
   localparam logic [5:0] RID_OP_RRC = 6'h0C;
   localparam int RID_OPC_HI = 15;
   localparam int RID_OPC_LO = 10;
   localparam int RID_DEST_BIT = 9;
   localparam int RID_BANK_BIT = 8;
   // ----------------------------------------
   // addressing
   // ----------------------------------------
   localparam logic [7:0] RID_INDEX_LIMIT = 8'h5F;
   localparam logic [7:0] RID_ACCESS_SPLIT = 8'h60;
   localparam logic [3:0] RID_ACCESS_HI_BANK = 4'hF;
   localparam logic [3:0] RID_ACCESS_LO_BANK = 4'h0;
   // ----------------------------------------
   // reset values and phases
   // ----------------------------------------
   localparam logic [7:0] RID_W_RST = 8'h00;
   localparam logic [11:0] RID_ADDR_RST = 12'h000;
   localparam logic RID_FLAG_RST = 1'b0;
   localparam logic [1:0] RID_PH_RST = 2'h0;
   typedef enum logic [1:0] {RID_Q1, RID_Q2, RID_Q3, RID_Q4} rid_phase_type;
endpackage

// ### testbench/rid_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
// --------
// data memory
// --------
module rid_mem_model (
   input wire logic clk_in,
   input wire logic [11:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic we_in,
   output logic [7:0] rdata_out
);
   logic [7:0] mem [0:4095];
   // preset so that offset 1Dh of each page holds zero
   initial for (int i = 0; i < 4096; i++) mem[i] = 8'(i * 7 + 8'h35);
   assign rdata_out = mem[addr_in];
   always @(posedge clk_in) if (we_in) mem[addr_in] <= wdata_in;
endmodule
`default_nettype wire

// ### testbench/tb_rotate_instruction_datapath.sv
`timescale 1ns/10ps
`default_nettype none
module tb_rotate_instruction_datapath;
   import rid_pkg::*;
   logic sys_clk_in = 1'b0, sys_rst_in = 1'b1, clk_en_in = 1'b1, instr_valid_in = 1'b0;
   logic ext_instr_set_in = 1'b0, carry_in = 1'b0, mem_we_out, carry_out, negative_out, zero_out, busy_out;
   logic [15:0] instr_in = 16'h0000;
   logic [3:0] bank_select_reg_in = 4'h0;
   logic [7:0] index_base_in = 8'h00, mem_rdata_in, mem_wdata_out, w_out;
   logic [11:0] mem_addr_out;
   int num_errors = 0, checks_done = 0, cyc = 0;
   always #12.5 sys_clk_in = ~sys_clk_in;
   rid_rotate_datapath i_dut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in),
      .instr_valid_in(instr_valid_in), .instr_in(instr_in), .bank_select_reg_in(bank_select_reg_in),
      .ext_instr_set_in(ext_instr_set_in), .index_base_in(index_base_in), .mem_rdata_in(mem_rdata_in),
      .carry_in(carry_in), .mem_addr_out(mem_addr_out), .mem_wdata_out(mem_wdata_out), .mem_we_out(mem_we_out),
      .w_out(w_out), .carry_out(carry_out), .negative_out(negative_out), .zero_out(zero_out), .busy_out(busy_out));
   rid_mem_model i_mem (.clk_in(sys_clk_in), .addr_in(mem_addr_out), .wdata_in(mem_wdata_out),
      .we_in(mem_we_out), .rdata_out(mem_rdata_in));
   // --------
   // helpers
   // --------
   task automatic results;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic exec(input logic rl, input logic d, input logic a, input logic [7:0] f, input logic c,
      input logic [11:0] ea);
      logic [7:0] src, res, w_old;
      src = i_mem.mem[ea];
      w_old = w_out;
      res = rl ? {src[6:0], src[7]} : {c, src[7:1]};
      instr_in <= {rl ? RID_OP_RLNC : RID_OP_RRC, d, a, f};
      carry_in <= c;
      instr_valid_in <= 1'b1;
      @(posedge sys_clk_in);
      instr_valid_in <= 1'b0;
      @(negedge sys_clk_in);
      cmp(busy_out, 12'h001);
      repeat (6) @(posedge sys_clk_in);
      cmp(mem_addr_out, ea);
      cmp(d ? i_mem.mem[ea] : w_out, res);
      cmp(i_mem.mem[ea], d ? res : src);
      cmp(w_out, d ? w_old : res);
      cmp({carry_out, negative_out, zero_out}, {rl ? c : src[0], res[7], res == 8'h00});
      cmp(busy_out, 12'h000);
   endtask
   // --------
   // scenarios
   // --------
   task automatic t_rrc;
      exec(1'b0, 1'b0, 1'b0, 8'h40, 1'b1, 12'h040);
      exec(1'b0, 1'b1, 1'b0, 8'h70, 1'b0, 12'hF70);
   endtask
   task automatic t_rlnc_bank;
      bank_select_reg_in <= 4'h7;
      exec(1'b1, 1'b1, 1'b1, 8'h1D, 1'b1, 12'h71D);
      exec(1'b1, 1'b0, 1'b1, 8'hC3, 1'b0, 12'h7C3);
   endtask
   // refused opcode, frozen enable, then reset in mid-instruction before the write
   task automatic t_freeze_reset;
      logic [7:0] src;
      src = i_mem.mem[12'h045];
      instr_in <= {6'h3F, 1'b1, 1'b0, 8'h45};
      instr_valid_in <= 1'b1;
      @(posedge sys_clk_in);
      instr_valid_in <= 1'b0;
      @(negedge sys_clk_in);
      cmp(busy_out, 12'h000);
      @(posedge sys_clk_in);
      instr_in <= {RID_OP_RRC, 1'b1, 1'b0, 8'h45};
      carry_in <= 1'b1;
      instr_valid_in <= 1'b1;
      @(posedge sys_clk_in);
      instr_valid_in <= 1'b0;
      clk_en_in <= 1'b0;
      repeat (5) @(posedge sys_clk_in);
      cmp(busy_out, 12'h001);
      cmp(mem_addr_out, 12'h045);
      clk_en_in <= 1'b1;
      repeat (2) @(posedge sys_clk_in);
      sys_rst_in <= 1'b1;
      repeat (2) @(posedge sys_clk_in);
      sys_rst_in <= 1'b0;
      @(negedge sys_clk_in);
      cmp({busy_out, mem_we_out, carry_out, negative_out, zero_out}, 12'h000);
      cmp(mem_addr_out, RID_ADDR_RST);
      cmp(w_out, RID_W_RST);
      cmp(mem_wdata_out, RID_W_RST);
      cmp(i_mem.mem[12'h045], src);
      @(posedge sys_clk_in);
      exec(1'b0, 1'b1, 1'b0, 8'h45, 1'b1, 12'h045);
   endtask
   task automatic t_indexed;
      ext_instr_set_in <= 1'b1;
      index_base_in <= 8'h20;
      exec(1'b1, 1'b0, 1'b0, 8'h5F, 1'b0, 12'h07F);
      exec(1'b0, 1'b1, 1'b0, 8'h60, 1'b1, 12'hF60);
      exec(1'b1, 1'b1, 1'b1, 8'h10, 1'b0, 12'h710);
   endtask
   always @(posedge sys_clk_in) begin
      cyc++;
      if (cyc == 2000) begin
         num_errors++;
         results();
      end
   end
   initial begin
      repeat (16) @(posedge sys_clk_in);
      sys_rst_in <= 1'b0;
      @(posedge sys_clk_in);
      t_rrc();
      t_rlnc_bank();
      t_freeze_reset();
      t_indexed();
      results();
   end
endmodule
`default_nettype wire
